// ==== src/dec_skip_pkg.sv ====
// Notes on behaviour
// (RULE1) opcode 0010 11da ffffffff is decrement_skip_on_zero
// (RULE2) opcode 0100 11da ffffffff is decrement_skip_on_nonzero
// (RULE3) skip-on-zero: file minus one to destination, skip when result is zero
// (RULE4) skip-on-nonzero: file minus one to destination, skip when result non-zero
// (RULE5) destination bit clear: result goes to accumulator, file register untouched
// (RULE6) destination bit set: result written back to the addressed file register
// (RULE7) bank bit clear selects access bank; set uses bank_selector_register bank
// (RULE8) bank clear, extended set on, address up to 95: indexed literal offset
// (RULE9) a skip discards the prefetched instruction and runs a no-operation cycle
// (RULE10) one word; one cycle without skip, two cycles with skip
// (RULE11) skipping a two-word instruction adds two idle cycles, three in total
// (RULE12) no arithmetic status flag changes
package dec_skip_pkg;
  localparam logic [3:0]  OPC_HI_ZERO    = 4'h2;
  localparam logic [3:0]  OPC_HI_NONZERO = 4'h4;
  localparam logic [1:0]  OPC_MID        = 2'h3;
  localparam logic [7:0]  LIT_OFS_LIMIT  = 8'h5F;
  localparam logic [3:0]  ACC_LOW_BANK   = 4'h0;
  localparam logic [3:0]  ACC_HIGH_BANK  = 4'hF;
  localparam logic [7:0]  ONE            = 8'h01;
  localparam logic [7:0]  ZERO           = 8'h00;
  localparam logic [1:0]  LAST_PHASE     = 2'h3;
  localparam logic [1:0]  PHASE_FIRST    = 2'h0;
  localparam logic [1:0]  ONE_NOP        = 2'h1;
  localparam logic [1:0]  TWO_NOP        = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_Q1   = 3'h1,
    S_Q2   = 3'h3,
    S_Q3   = 3'h2,
    S_Q4   = 3'h6,
    S_NOP  = 3'h7
  } state_t;

  typedef struct packed {
    logic [3:0] hi;
    logic [1:0] mid;
    logic       dest;
    logic       bank;
    logic [7:0] faddr;
  } instr_t;

  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  data;
  } file_req_t;
endpackage

`timescale 1ns/1ps
`default_nettype none
module dec_unit
  import dec_skip_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       load,
  input  wire logic       on_zero,
  input  wire logic [7:0] operand,
  output logic      [7:0] result_r,
  output logic            skip_r
);
  logic [7:0] diff;

  assign diff = operand - ONE;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      result_r <= ZERO;
      skip_r   <= 1'b0;
    end else if (load) begin
      result_r <= diff;
      skip_r   <= on_zero ? (diff == ZERO) : (diff != ZERO); // RULE3 RULE4
    end
  end

  AST_SKIP_SENSE: assert property (@(posedge clock) disable iff (!nrst) // RULE3
    load |=> skip_r == ($past(on_zero) ? (result_r == ZERO) : (result_r != ZERO)))
    else $error("skip decision disagrees with result");
endmodule
`default_nettype wire

// ==== src/dec_skip_core.sv ====
`timescale 1ns/1ps
`default_nettype none
// one clock per Q phase; four clocks make one instruction cycle
module dec_skip_core
  import dec_skip_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  input  wire logic        next_two_word,
  input  wire logic        ext_set_en,
  input  wire logic [3:0]  bank_selector_register,
  input  wire logic [11:0] index_base,
  input  wire logic [7:0]  file_rdata,
  output logic             busy_r,
  output logic             file_rd_r,
  output logic [11:0]      file_addr_r,
  output logic             file_wr_r,
  output logic [7:0]       file_wdata_r,
  output logic             w_wr_r,
  output logic [7:0]       w_wdata_r,
  output logic             status_wr_r,
  output logic             discard_r,
  output logic             nop_cycle_r
);
  state_t     state_r;
  state_t     state_nxt;
  instr_t     ins_r;
  instr_t     ins_in;
  logic       match;
  logic [1:0] phase_r;
  logic [1:0] nops_r;
  logic       next_two_r;
  logic [7:0] result;
  logic       skip;
  logic [11:0] addr_nxt;

  assign ins_in = instr_t'(instr);
  assign match  = (ins_in.mid == OPC_MID) && // RULE1 RULE2
                  ((ins_in.hi == OPC_HI_ZERO) || (ins_in.hi == OPC_HI_NONZERO));

  always_comb begin
    if (ins_r.bank) begin
      addr_nxt = {bank_selector_register, ins_r.faddr}; // RULE7
    end else if (ext_set_en && ins_r.faddr <= LIT_OFS_LIMIT) begin
      addr_nxt = index_base + {4'h0, ins_r.faddr}; // RULE8
    end else if (ins_r.faddr <= LIT_OFS_LIMIT) begin
      addr_nxt = {ACC_LOW_BANK, ins_r.faddr}; // RULE7
    end else begin
      addr_nxt = {ACC_HIGH_BANK, ins_r.faddr};
    end
  end

  dec_unit u_dec (
    .clock    (clock),
    .nrst     (nrst),
    .load     (state_r == S_Q2),
    .on_zero  (ins_r.hi == OPC_HI_ZERO),
    .operand  (file_rdata),
    .result_r (result),
    .skip_r   (skip)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (instr_valid && match) begin
          state_nxt = S_Q1;
        end
      end
      S_Q1: state_nxt = S_Q2;
      S_Q2: state_nxt = S_Q3;
      S_Q3: state_nxt = S_Q4;
      S_Q4: state_nxt = skip ? S_NOP : S_IDLE; // RULE9 RULE10
      S_NOP: begin
        if (phase_r == LAST_PHASE && nops_r == ONE_NOP) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // the prefetch tells us the follower's length while it sits in the queue
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ins_r      <= instr_t'(16'h0000);
      next_two_r <= 1'b0;
    end else if (state_r == S_IDLE && instr_valid && match) begin
      ins_r      <= ins_in;
      next_two_r <= next_two_word;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase_r <= PHASE_FIRST;
      nops_r  <= 2'h0;
    end else if (state_r == S_Q4) begin
      phase_r <= PHASE_FIRST;
      nops_r  <= next_two_r ? TWO_NOP : ONE_NOP; // RULE11
    end else if (state_r == S_NOP) begin
      phase_r <= phase_r + 2'h1;
      if (phase_r == LAST_PHASE) begin
        nops_r <= nops_r - 2'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_r      <= 1'b0;
      nop_cycle_r <= 1'b0;
      discard_r   <= 1'b0;
    end else begin
      busy_r      <= state_nxt != S_IDLE;
      nop_cycle_r <= state_nxt == S_NOP; // RULE9 RULE11
      discard_r   <= state_r == S_Q4 && skip; // RULE9
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      file_rd_r   <= 1'b0;
      file_addr_r <= 12'h000;
    end else begin
      file_rd_r <= state_r == S_Q1;
      if (state_r == S_Q1) begin
        file_addr_r <= addr_nxt;
      end
    end
  end

  // writes land in Q4; accumulator and file port never both fire
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      file_wr_r    <= 1'b0;
      file_wdata_r <= ZERO;
      w_wr_r       <= 1'b0;
      w_wdata_r    <= ZERO;
    end else begin
      file_wr_r <= state_r == S_Q3 && ins_r.dest; // RULE6
      w_wr_r    <= state_r == S_Q3 && !ins_r.dest; // RULE5
      if (state_r == S_Q3) begin
        file_wdata_r <= result;
        w_wdata_r    <= result;
      end
    end
  end

  // status flags are owned elsewhere; this path never requests a write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      status_wr_r <= 1'b0;
    end else begin
      status_wr_r <= 1'b0; // RULE12
    end
  end

  sequence seq_exec;
    state_r == S_Q1 ##1 state_r == S_Q2 ##1 state_r == S_Q3 ##1 state_r == S_Q4;
  endsequence

  AST_DECODE: assert property (@(posedge clock) disable iff (!nrst) // RULE1
    state_r == S_IDLE && instr_valid && match |=> seq_exec)
    else $error("matched opcode not executed");

  AST_NO_FOREIGN: assert property (@(posedge clock) disable iff (!nrst) // RULE2
    state_r == S_IDLE && !(instr_valid && match) |=> state_r == S_IDLE)
    else $error("non matching opcode started execution");

  AST_DEST_W: assert property (@(posedge clock) disable iff (!nrst) // RULE5
    state_r == S_Q3 && !ins_r.dest |=> w_wr_r && !file_wr_r && w_wdata_r == result)
    else $error("accumulator write wrong");

  AST_DEST_F: assert property (@(posedge clock) disable iff (!nrst) // RULE6
    state_r == S_Q3 && ins_r.dest |=> file_wr_r && !w_wr_r && file_wdata_r == result)
    else $error("file write wrong");

  AST_BANKED: assert property (@(posedge clock) disable iff (!nrst) // RULE7
    state_r == S_Q1 && ins_r.bank |=> file_addr_r == {$past(bank_selector_register), ins_r.faddr})
    else $error("banked address wrong");

  AST_INDEXED: assert property (@(posedge clock) disable iff (!nrst) // RULE8
    state_r == S_Q1 && !ins_r.bank && ext_set_en && ins_r.faddr <= LIT_OFS_LIMIT
    |=> file_addr_r == $past(index_base) + {4'h0, ins_r.faddr})
    else $error("indexed literal offset address wrong");

  AST_ONE_CYCLE: assert property (@(posedge clock) disable iff (!nrst) // RULE10
    state_r == S_Q4 && !skip |=> state_r == S_IDLE && !nop_cycle_r)
    else $error("unskipped instruction overran");

  AST_SKIP_ONE: assert property (@(posedge clock) disable iff (!nrst) // RULE9
    state_r == S_Q4 && skip && !next_two_r
    |=> discard_r && nop_cycle_r ##1 nop_cycle_r [*3] ##1 !nop_cycle_r)
    else $error("single skip cycle wrong");

  AST_SKIP_TWO: assert property (@(posedge clock) disable iff (!nrst) // RULE11
    state_r == S_Q4 && skip && next_two_r |=> nop_cycle_r [*8] ##1 !nop_cycle_r)
    else $error("two word skip length wrong");

  AST_IDLE_NOP: assert property (@(posedge clock) disable iff (!nrst) // RULE11
    nop_cycle_r |-> !file_rd_r && !file_wr_r && !w_wr_r)
    else $error("activity during no-operation cycle");

  AST_NO_STATUS: assert property (@(posedge clock) disable iff (!nrst) // RULE12
    busy_r |-> !status_wr_r)
    else $error("status write requested");
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dec_skip_pkg::*;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        instr_valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic        next_two_word = 1'b0;
  logic        ext_set_en = 1'b0;
  logic [3:0]  bank_selector_register = 4'h0;
  logic [11:0] index_base = 12'h000;
  logic [7:0]  file_rdata = 8'h00;
  logic        busy_r, file_rd_r, file_wr_r, w_wr_r, status_wr_r, discard_r, nop_cycle_r;
  logic [11:0] file_addr_r;
  logic [7:0]  file_wdata_r, w_wdata_r;
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;

  dec_skip_core i_dut (.clock(clock), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
    .next_two_word(next_two_word), .ext_set_en(ext_set_en),
    .bank_selector_register(bank_selector_register), .index_base(index_base),
    .file_rdata(file_rdata), .busy_r(busy_r), .file_rd_r(file_rd_r),
    .file_addr_r(file_addr_r), .file_wr_r(file_wr_r), .file_wdata_r(file_wdata_r),
    .w_wr_r(w_wr_r), .w_wdata_r(w_wdata_r), .status_wr_r(status_wr_r),
    .discard_r(discard_r), .nop_cycle_r(nop_cycle_r));

  initial begin
    forever #12.5 clock = ~clock;
  end

  task automatic test_done();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // generous ceiling: all scenarios need well under 200 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc >= 2000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one instruction from acceptance to the first idle cycle; called just after an edge
  task automatic exec(input logic [15:0] ins, input logic tw, input logic [7:0] rd,
                      input logic [11:0] ea);
    logic [7:0] r;
    logic       sk;
    int         n;
    r = rd - ONE;
    sk = (ins[15:12] == OPC_HI_ZERO) ? (r == ZERO) : (r != ZERO);
    instr_valid = 1'b1;
    instr = ins;
    next_two_word = tw;
    @(posedge clock); #2 instr_valid = 1'b0;
    chk(busy_r, 1'b1);
    @(posedge clock); #2 chk(file_rd_r, 1'b1);
    chk(file_addr_r, ea);
    file_rdata = rd;
    @(posedge clock); #2 file_rdata = ~rd;
    @(posedge clock); #2 chk(file_wr_r, ins[9]);
    chk(w_wr_r, !ins[9]);
    chk(ins[9] ? file_wdata_r : w_wdata_r, r);
    chk(status_wr_r, 1'b0);
    @(posedge clock); #2 chk(discard_r, sk);
    n = 0;
    while (nop_cycle_r === 1'b1 && n < 20) begin
      n++;
      @(posedge clock); #2;
    end
    chk(16'(n), sk ? (tw ? 16'h0008 : 16'h0004) : 16'h0000);
    chk(busy_r, 1'b0);
  endtask

  task automatic t_zero_skip();
    exec(16'h2E10, 1'b0, 8'h01, 12'h010);
    exec(16'h2C80, 1'b1, 8'h01, 12'hF80);
    $display("test zero_skip done");
  endtask

  task automatic t_zero_noskip();
    exec(16'h2C20, 1'b1, 8'h00, 12'h020);
    $display("test zero_noskip done");
  endtask

  task automatic t_nonzero();
    exec(16'h4E30, 1'b1, 8'h05, 12'h030);
    bank_selector_register = 4'h5;
    exec(16'h4FA7, 1'b0, 8'h01, 12'h5A7);
    exec(16'h4D00, 1'b0, 8'h00, 12'h500);
    $display("test nonzero done");
  endtask

  task automatic t_indexed();
    ext_set_en = 1'b1;
    index_base = 12'hFF0;
    exec(16'h2E5F, 1'b0, 8'h09, 12'h04F);
    exec(16'h2E60, 1'b0, 8'h09, 12'hF60);
    exec(16'h2F5F, 1'b0, 8'h09, 12'h55F);
    ext_set_en = 1'b0;
    $display("test indexed done");
  endtask

  task automatic t_other_opcode();
    instr_valid = 1'b1;
    instr = 16'h2A10;
    repeat (3) @(posedge clock);
    #2 chk(busy_r, 1'b0);
    chk(file_rd_r, 1'b0);
    instr_valid = 1'b0;
    $display("test other_opcode done");
  endtask

  initial begin
    repeat (4) @(posedge clock);
    #2 nrst = 1'b1;
    t_zero_skip();
    t_zero_noskip();
    t_nonzero();
    t_indexed();
    t_other_opcode();
    test_done();
  end
endmodule
`default_nettype wire
